/* File: core/rss_reset_sequencer.sv */
// Reset-source sequencer: merges power-on, pin, brownout and watchdog
// resets into one delayed core reset and records the cause.
// Assumes rstn is the power-on detector output, fuses are static,
// and the watchdog timeout is a pulse on clk_sys.
`timescale 1ns/1ps

module rss_reset_sequencer #(
   parameter bit EXTENDED = 1'b1, // Four-flag layout when set
   parameter int CK_6_N = 6, // Short clock count
   parameter int CK_1K_N = 1024, // 1K clock count
   parameter int CK_16K_N = 16384, // 16K clock count
   parameter int CK_32K_N = 32768, // 32K clock count
   parameter int RT_SHORT_LO = 256, // Oscillator ticks, short, low trip
   parameter int RT_LONG_LO = 4096, // Oscillator ticks, long, low trip
   parameter int RT_SHORT_HI = 1024, // Oscillator ticks, short, high trip
   parameter int RT_LONG_HI = 16384, // Oscillator ticks, long, high trip
   parameter int TICK_CYC = rss_pkg::WDT_TICK_CYC // Cycles per tick
) (
   input wire logic clk_sys, // System clock
   input wire logic rstn, // Power-on detector, low while supply low
   input wire logic ext_reset_n, // External reset pin, asynchronous
   input wire logic brownout_detector, // High while supply below trip
   input wire logic wdt_timeout, // Watchdog timeout pulse
   input wire logic wake_start, // Wake from sleep pulse
   input wire rss_pkg::rss_fuses_t fuses, // Fuse settings
   input wire logic hsel, // AHB slave select
   input wire logic [31:0] haddr, // AHB address
   input wire logic [1:0] htrans, // AHB transfer type
   input wire logic hwrite, // AHB write
   input wire logic [2:0] hsize, // AHB size, word only
   input wire logic [31:0] hwdata, // AHB write data
   input wire logic hready, // AHB ready in
   output logic [31:0] hrdata, // AHB read data
   output logic hreadyout, // AHB ready out
   output logic hresp, // AHB response, always OKAY
   output logic core_rst_n, // Core reset, active low
   output logic wdt_rst_pulse, // One-cycle watchdog reset pulse
   output logic wake_hold, // Clock settle hold after wake
   output logic bod_level_sel // Trip level select, high is 2.7V
);

   // ==========================================================
   // Delay table decoding
   // ==========================================================
   // Real-time part for a clock-select setting
   function automatic rss_pkg::rss_rt_t rt_code(input logic [3:0] cs);
      case (cs)
         4'hE, 4'hB, 4'h6, 4'h3, 4'h0: rt_code = rss_pkg::RT_SHORT;
         4'hD, 4'hA, 4'h9, 4'h8, 4'h5, 4'h2: rt_code = rss_pkg::RT_LONG;
         default: rt_code = rss_pkg::RT_NONE;
      endcase
   endfunction : rt_code

   // Clock-counting part for a clock-select setting
   function automatic rss_pkg::rss_ck_t ck_code(input logic [3:0] cs);
      case (cs)
         4'hF, 4'hE, 4'hD, 4'h9: ck_code = rss_pkg::CK_1K;
         4'hC, 4'hB, 4'hA: ck_code = rss_pkg::CK_16K;
         4'h8: ck_code = rss_pkg::CK_32K;
         default: ck_code = rss_pkg::CK_6;
      endcase
   endfunction : ck_code

   // ==========================================================
   // Declarations
   // ==========================================================
   logic [2:0] pin_sync; // Pin synchroniser chain
   logic [2:0] bod_sync; // Detector synchroniser chain
   logic pin_low; // Filtered pin low level
   logic bod_low; // Filtered detector level
   logic [15:0] bod_cnt; // Drop persistence counter
   logic bod_act; // Brownout reset active
   logic wdt_pulse; // Registered watchdog pulse
   logic [15:0] div_cnt; // Oscillator tick divider
   logic wdt_tick; // Oscillator tick enable
   rss_pkg::rss_state_t state; // Sequencer state
   rss_pkg::rss_state_t next_state; // Next sequencer state
   logic [15:0] rt_cnt; // Real-time ticks left
   logic [15:0] next_rt; // Next real-time count
   logic [15:0] ck_cnt; // Clock cycles left
   logic [15:0] next_ck; // Next clock count
   rss_pkg::rss_flags_t flags; // Cause flags
   rss_pkg::rss_flags_t next_flags; // Next cause flags
   logic wr_hit; // Pending write targets status

   // ==========================================================
   // Combinational decoding
   // ==========================================================
   wire core_arst_n = rstn & ext_reset_n; // Asynchronous reset term
   wire pin_agree = pin_sync[1] == pin_sync[2]; // Pin stages agree
   wire bod_agree = bod_sync[1] == bod_sync[2]; // Detector agrees
   wire [15:0] bod_lim = fuses.brownout_level_fuse ?
      16'(rss_pkg::BOD_HI_CYC) : 16'(rss_pkg::BOD_LO_CYC);
   wire bod_arm = bod_low & fuses.brownout_enable_fuse;
   wire src_act = pin_low | bod_act | wdt_pulse; // Any source holds
   wire rss_pkg::rss_rt_t rt_sel = rt_code(fuses.clock_select_fuses);
   wire rss_pkg::rss_ck_t ck_sel = ck_code(fuses.clock_select_fuses);
   wire [15:0] rt_short = fuses.brownout_level_fuse ?
      16'(RT_SHORT_HI) : 16'(RT_SHORT_LO);
   wire [15:0] rt_long = fuses.brownout_level_fuse ?
      16'(RT_LONG_HI) : 16'(RT_LONG_LO);
   wire [15:0] rt_len = (rt_sel == rss_pkg::RT_SHORT) ? rt_short :
      (rt_sel == rss_pkg::RT_LONG) ? rt_long : 16'h0000;
   wire [15:0] ck_len = (ck_sel == rss_pkg::CK_1K) ? 16'(CK_1K_N) :
      (ck_sel == rss_pkg::CK_16K) ? 16'(CK_16K_N) :
      (ck_sel == rss_pkg::CK_32K) ? 16'(CK_32K_N) : 16'(CK_6_N);
   wire addr_ok = hsel & htrans[1] & hready; // Address phase taken
   wire addr_stat = haddr == rss_pkg::ADDR_STATUS; // Status decode
   wire rd_hit = addr_ok & ~hwrite & addr_stat; // Status read
   wire [3:0] lay_mask = EXTENDED ? rss_pkg::MASK_EXT :
      rss_pkg::MASK_BASIC;
   wire [3:0] clr_bits = wr_hit ? (~hwdata[3:0] & lay_mask) : 4'h0;
   wire [3:0] set_bits = {EXTENDED & wdt_pulse, EXTENDED & bod_act,
      pin_low, 1'b0};
   wire next_run = (next_state == rss_pkg::ST_RUN) |
      (next_state == rss_pkg::ST_WAKE);

   // ==========================================================
   // Input synchronisers and filters
   // ==========================================================
   // Three stages; level changes once stages two and three agree
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pin_sync <= 3'h7;
         bod_sync <= 3'h0;
         pin_low <= 1'b0;
         bod_low <= 1'b0;
      end else begin
         pin_sync <= {pin_sync[1:0], ext_reset_n};
         bod_sync <= {bod_sync[1:0], brownout_detector};
         if (pin_agree) begin
            pin_low <= ~pin_sync[2];
         end
         if (bod_agree) begin
            bod_low <= bod_sync[2];
         end
      end
   end

   // Drop must persist before it counts; release is at once
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bod_cnt <= 16'h0000;
         bod_act <= 1'b0;
      end else if (!bod_arm) begin
         bod_cnt <= 16'h0000;
         bod_act <= 1'b0;
      end else if (bod_cnt >= bod_lim - 16'h0001) begin
         bod_act <= 1'b1;
      end else begin
         bod_cnt <= bod_cnt + 16'h0001;
      end
   end

   // Watchdog pulse and trip level select
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wdt_pulse <= 1'b0;
         wdt_rst_pulse <= 1'b0;
         bod_level_sel <= 1'b0;
      end else begin
         wdt_pulse <= wdt_timeout;
         wdt_rst_pulse <= wdt_timeout;
         bod_level_sel <= fuses.brownout_level_fuse;
      end
   end

   // Stand-in for the watchdog oscillator, one tick per period
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div_cnt <= 16'h0000;
         wdt_tick <= 1'b0;
      end else begin
         wdt_tick <= div_cnt == 16'(TICK_CYC - 1);
         div_cnt <= (div_cnt == 16'(TICK_CYC - 1)) ? 16'h0000 :
            div_cnt + 16'h0001;
      end
   end

   // ==========================================================
   // Start-up sequencer
   // ==========================================================
   // Any active source forces hold; its release loads the delay
   always_comb begin
      next_state = state;
      next_rt = rt_cnt;
      next_ck = ck_cnt;
      if (src_act) begin
         next_state = rss_pkg::ST_HOLD;
      end else begin
         case (state)
            rss_pkg::ST_HOLD: begin
               next_state = rss_pkg::ST_RT;
               next_rt = rt_len;
               next_ck = ck_len;
            end
            rss_pkg::ST_RT: begin
               if (rt_cnt == 16'h0000) begin
                  next_state = rss_pkg::ST_CK;
               end else if (wdt_tick) begin
                  next_rt = rt_cnt - 16'h0001;
               end
            end
            rss_pkg::ST_CK: begin
               if (ck_cnt <= 16'h0001) begin
                  next_state = rss_pkg::ST_RUN;
               end else begin
                  next_ck = ck_cnt - 16'h0001;
               end
            end
            rss_pkg::ST_RUN: begin
               if (wake_start) begin
                  next_state = rss_pkg::ST_WAKE;
                  next_ck = ck_len;
               end
            end
            rss_pkg::ST_WAKE: begin
               if (ck_cnt <= 16'h0001) begin
                  next_state = rss_pkg::ST_RUN;
               end else begin
                  next_ck = ck_cnt - 16'h0001;
               end
            end
            default: begin
               next_state = rss_pkg::ST_HOLD;
            end
         endcase
      end
   end

   // Sequencer registers; power-on starts in hold
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= rss_pkg::ST_HOLD;
         rt_cnt <= 16'h0000;
         ck_cnt <= 16'h0000;
         wake_hold <= 1'b0;
      end else begin
         state <= next_state;
         rt_cnt <= next_rt;
         ck_cnt <= next_ck;
         wake_hold <= next_state == rss_pkg::ST_WAKE;
      end
   end

   // Pin reaches the core reset without the clock running
   always_ff @(posedge clk_sys or negedge core_arst_n) begin
      if (!core_arst_n) begin
         core_rst_n <= 1'b0;
      end else begin
         // Stay low until the pin filter has seen the pulse; this also
         // keeps a 1 off D while the pin lets the reset go
         core_rst_n <= next_run & (&pin_sync[2:1]);
      end
   end

   // ==========================================================
   // Cause register and AHB-Lite slave
   // ==========================================================
   // Set wins over a zero write in the same cycle
   always_comb begin
      next_flags = (flags & ~clr_bits) | set_bits;
   end

   // Power-on sets its own flag and clears the rest
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flags <= rss_pkg::FLAGS_RST;
      end else begin
         flags <= next_flags;
      end
   end

   // Zero-wait slave; reads see this cycle's update
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_hit <= 1'b0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_hit <= addr_ok & hwrite & addr_stat;
         hrdata <= rd_hit ? {28'h000_0000, next_flags & lay_mask} :
            32'h0000_0000;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking chk_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   chk_src_holds_core: assert property (src_act |=> !core_rst_n)
      else $error("core reset released while a source is active");
   chk_wdt_pulse_end: assert property (
      $fell(wdt_pulse) && !src_act |->
      state == rss_pkg::ST_HOLD ##1 state == rss_pkg::ST_RT)
      else $error("delay did not start after watchdog pulse");
   chk_release_after_ck: assert property ($rose(core_rst_n) |->
      $past(state) == rss_pkg::ST_CK && $past(ck_cnt) <= 16'h0001)
      else $error("core released before clock count ran out");
   chk_bod_persist: assert property ($rose(bod_act) |->
      $past(bod_cnt) >= bod_lim - 16'h0001 && $past(bod_arm))
      else $error("brownout taken before its filter time");
   chk_bod_disabled: assert property (
      !fuses.brownout_enable_fuse |=> !bod_act)
      else $error("brownout active with the enable fuse clear");
   chk_set_beats_clr: assert property (
      wr_hit && pin_low |=> flags.pin_reset_flag)
      else $error("pin flag lost to a same-cycle clear");
   chk_one_keeps: assert property (
      wr_hit && hwdata[rss_pkg::BIT_POR] && flags.power_on_flag |=>
      flags.power_on_flag)
      else $error("writing one changed the power-on flag");
   chk_zero_clears: assert property (
      wr_hit && !hwdata[rss_pkg::BIT_POR] |=> !flags.power_on_flag)
      else $error("writing zero did not clear the power-on flag");
   chk_reserved_zero: assert property (
      hrdata[31:4] == 28'h000_0000 && (EXTENDED || hrdata[3:2] == 2'b00))
      else $error("reserved status bits read nonzero");
   chk_wake_no_reset: assert property (
      state == rss_pkg::ST_RUN && wake_start && !src_act &&
      (&pin_sync[2:1]) |=> wake_hold && core_rst_n)
      else $error("wake delay touched the core reset");

   cov_pin_reset: cover property ($fell(pin_low) ##[1:1000] $rose(core_rst_n));
   cov_wdt_reset: cover property (wdt_pulse ##[1:1000] $rose(core_rst_n));
   cov_bod_reset: cover property ($rose(bod_act));
   cov_wake: cover property ($fell(wake_hold));

endmodule : rss_reset_sequencer

/* File: core/rss_pkg.sv */
// Constants, types and register map of the reset-source sequencer.
// Assumes a single 50 MHz system clock and one AHB-Lite master.
package rss_pkg;

   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 20; // System clock period
   localparam int PIN_PULSE_NS = 50; // Shortest pin pulse to be caught
   // Pin pulse in cycles, rounded up
   localparam int PIN_PULSE_CYC =
      (PIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BOD_HI_NS = 7000; // Drop filter at upper trip level
   localparam int BOD_LO_NS = 24000; // Drop filter at lower trip level
   // Least persistence in cycles, rounded up
   localparam int BOD_HI_CYC =
      (BOD_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BOD_LO_CYC =
      (BOD_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WDT_OSC_NS = 14000; // Watchdog oscillator period
   // Oscillator period in cycles, rounded down
   localparam int WDT_TICK_CYC = WDT_OSC_NS / CLK_PERIOD_NS;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [31:0] ADDR_STATUS = 32'h0000_0034; // Cause register
   localparam int BIT_POR = 0; // Power-on flag
   localparam int BIT_PIN = 1; // Pin reset flag
   localparam int BIT_BOD = 2; // Brownout flag
   localparam int BIT_WDT = 3; // Watchdog flag
   localparam logic [3:0] FLAGS_RST = 4'h1; // Power-on flag set
   localparam logic [3:0] MASK_BASIC = 4'h3; // Basic layout bits
   localparam logic [3:0] MASK_EXT = 4'hF; // Extended layout bits

   // ==========================================================
   // Types
   // ==========================================================
   // Real-time part of the start-up delay
   typedef enum logic [1:0] {
      RT_NONE = 2'b00,
      RT_SHORT = 2'b01,
      RT_LONG = 2'b10
   } rss_rt_t;

   // Clock-counting part of the start-up delay
   typedef enum logic [1:0] {
      CK_6 = 2'b00,
      CK_1K = 2'b01,
      CK_16K = 2'b10,
      CK_32K = 2'b11
   } rss_ck_t;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_HOLD = 3'b000,
      ST_RT = 3'b001,
      ST_CK = 3'b010,
      ST_RUN = 3'b011,
      ST_WAKE = 3'b100
   } rss_state_t;

   // Fuse settings, static while powered
   typedef struct packed {
      logic [3:0] clock_select_fuses;
      logic brownout_enable_fuse;
      logic brownout_level_fuse;
   } rss_fuses_t;

   // Cause flags in register bit order
   typedef struct packed {
      logic watchdog_reset_flag;
      logic brownout_reset_flag;
      logic pin_reset_flag;
      logic power_on_flag;
   } rss_flags_t;

endpackage : rss_pkg

/* File: testbench/rss_source_model.sv */
// Model of the parties outside the sequencer: supply detector,
// reset pin, brownout detector and watchdog timer.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module rss_source_model (
   input wire logic clk_sys, // System clock
   output logic rstn, // Supply detector, low while supply low
   output logic ext_reset_n, // Reset pin level
   output logic brownout_detector, // High while supply below trip
   output logic wdt_timeout // Watchdog time-out pulse
);
   // ==========================================================
   // Power-up levels
   // ==========================================================
   // Supply starts low; pin pulled high when nobody drives it
   initial begin
      rstn = 1'b0;
      ext_reset_n = 1'b1;
      brownout_detector = 1'b0;
      wdt_timeout = 1'b0;
   end

   // ==========================================================
   // Level setters
   // ==========================================================
   // Supply detector level
   task automatic set_supply(input logic ok);
      rstn <= ok;
   endtask : set_supply

   // Holding the pin low may stretch any reset
   task automatic set_pin(input logic lvl);
      ext_reset_n <= lvl;
   endtask : set_pin

   // Brownout detector level
   task automatic set_brown(input logic low);
      brownout_detector <= low;
   endtask : set_brown

   // Time-out lasts exactly one clock, as the timer gives it
   task automatic fire_wdt;
      wdt_timeout <= 1'b1;
      @(posedge clk_sys);
      wdt_timeout <= 1'b0;
   endtask : fire_wdt
endmodule : rss_source_model

/* File: testbench/tb.sv */
// Self-checking bench of the reset-source sequencer, extended layout.
// Assumes the source model drives all reset causes and the bench is
// the only bus master; delay counts are shortened by parameters.
`timescale 1ns/1ps
module tb;
   // ==========================================================
   // Signals
   // ==========================================================
   localparam logic [31:0] ADDR = rss_pkg::ADDR_STATUS; // Cause reg
   localparam int BHI = rss_pkg::BOD_HI_CYC; // Upper-trip filter
   logic clk_sys = 1'b0; // System clock
   logic rstn, ext_reset_n, brownout_detector, wdt_timeout; // Causes
   logic wake_start = 1'b0; // Wake pulse
   logic hsel = 1'b0; // Bus select
   logic [31:0] haddr = 32'h0; // Bus address
   logic [1:0] htrans = 2'h0; // Transfer type
   logic hwrite = 1'b0; // Direction
   logic [2:0] hsize = 3'h2; // Word size
   logic [31:0] hwdata = 32'h0; // Write data
   logic [31:0] hrdata; // Read data
   logic hreadyout, hresp, core_rst_n, wdt_rst_pulse; // Outputs
   logic wake_hold, bod_level_sel; // Outputs
   // Static fuses: short clock count, brownout on at upper trip
   rss_pkg::rss_fuses_t fuses = 6'h13;
   int fails = 0; // Mismatch count
   int n_checks = 0; // Comparison count
   int cycles = 0; // Timeout counter

   // ==========================================================
   // Clock, partner and design
   // ==========================================================
   always #10 clk_sys = ~clk_sys;

   rss_source_model i_rss_source_model (.clk_sys(clk_sys), .rstn(rstn),
      .ext_reset_n(ext_reset_n), .brownout_detector(brownout_detector),
      .wdt_timeout(wdt_timeout));

   // Long counts shortened so the run stays brief
   rss_reset_sequencer #(.TICK_CYC(2), .RT_SHORT_LO(4), .RT_LONG_LO(4),
      .RT_SHORT_HI(4), .RT_LONG_HI(4), .CK_1K_N(8), .CK_16K_N(16),
      .CK_32K_N(16)) i_rss_reset_sequencer (.clk_sys(clk_sys),
      .rstn(rstn), .ext_reset_n(ext_reset_n),
      .brownout_detector(brownout_detector), .wdt_timeout(wdt_timeout),
      .wake_start(wake_start), .fuses(fuses), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .core_rst_n(core_rst_n),
      .wdt_rst_pulse(wdt_rst_pulse), .wake_hold(wake_hold),
      .bod_level_sel(bod_level_sel));

   // ==========================================================
   // Reporting
   // ==========================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // Hang guard, far above the expected run length
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         wrap_up();
      end
   end

   // ==========================================================
   // Bus and wait helpers
   // ==========================================================
   // One single transfer; only the hang guard ends a wait on ready
   task automatic bus_cycle(input logic [31:0] a, input logic wr,
      input logic [31:0] wd, output logic [31:0] rd_v);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do begin @(posedge clk_sys); end while (!hreadyout);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge clk_sys); end while (!hreadyout);
      rd_v = hrdata;
      check(hresp, 1'b0);
   endtask : bus_cycle

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      bus_cycle(a, 1'b1, d, dummy);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] d;
      bus_cycle(a, 1'b0, 32'h0, d);
      check(d, exp);
   endtask : rd

   // Waits for core release, bounded
   task automatic wait_release(input int max);
      int n;
      n = 0;
      while (core_rst_n !== 1'b1 && n < max) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask : wait_release

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_power_on;
      @(posedge clk_sys);
      i_rss_source_model.set_supply(1'b1);
      repeat (4) @(posedge clk_sys);
      #1;
      check(core_rst_n, 1'b0);
      wait_release(60);
      check(core_rst_n, 1'b1);
      rd(ADDR, 32'h1);
      wr(ADDR, 32'h0);
      rd(ADDR, 32'h0);
      $display("test power_on done");
   endtask : t_power_on

   task automatic t_pin;
      @(posedge clk_sys);
      i_rss_source_model.set_pin(1'b0);
      #1;
      check(core_rst_n, 1'b0);
      repeat (5) @(posedge clk_sys);
      wr(ADDR, 32'h0); // Clear races the still-low pin
      rd(ADDR, 32'h2);
      @(posedge clk_sys);
      i_rss_source_model.set_pin(1'b1);
      repeat (4) @(posedge clk_sys);
      #1;
      check(core_rst_n, 1'b0);
      wait_release(40);
      check(core_rst_n, 1'b1);
      wr(ADDR, 32'hF);
      rd(ADDR, 32'h2);
      wr(ADDR, 32'h0);
      rd(ADDR, 32'h0);
      $display("test pin done");
   endtask : t_pin

   task automatic t_wdt;
      @(posedge clk_sys);
      i_rss_source_model.fire_wdt();
      #1;
      check(wdt_rst_pulse, 1'b1);
      @(posedge clk_sys);
      #1;
      check(wdt_rst_pulse, 1'b0);
      @(posedge clk_sys);
      #1;
      check(core_rst_n, 1'b0);
      wait_release(40);
      check(core_rst_n, 1'b1);
      rd(ADDR, 32'h8);
      $display("test watchdog done");
   endtask : t_wdt

   // Short drop filtered out, long drop resets
   task automatic t_brown;
      check(bod_level_sel, 1'b1);
      @(posedge clk_sys);
      i_rss_source_model.set_brown(1'b1);
      repeat (100) @(posedge clk_sys);
      i_rss_source_model.set_brown(1'b0);
      repeat (10) @(posedge clk_sys);
      #1;
      check(core_rst_n, 1'b1);
      @(posedge clk_sys);
      i_rss_source_model.set_brown(1'b1);
      repeat (BHI - 10) @(posedge clk_sys);
      #1;
      check(core_rst_n, 1'b1);
      repeat (30) @(posedge clk_sys);
      #1;
      check(core_rst_n, 1'b0);
      @(posedge clk_sys);
      i_rss_source_model.set_brown(1'b0);
      repeat (3) @(posedge clk_sys);
      #1;
      check(core_rst_n, 1'b0);
      wait_release(60);
      check(core_rst_n, 1'b1);
      rd(ADDR, 32'hC);
      $display("test brownout done");
   endtask : t_brown

   // Reserved bits stay zero under an all-ones write
   task automatic t_layout;
      wr(ADDR, 32'hFFFF_FFFF);
      rd(ADDR, 32'hC);
      rd(ADDR + 32'h4, 32'h0);
      wr(ADDR, 32'h0);
      rd(ADDR, 32'h0);
      $display("test layout done");
   endtask : t_layout

   // Wake holds only the clock count, core keeps running
   task automatic t_wake;
      int n;
      n = 0;
      @(posedge clk_sys);
      wake_start <= 1'b1;
      @(posedge clk_sys);
      wake_start <= 1'b0;
      while (wake_hold !== 1'b1 && n < 5) begin @(posedge clk_sys); n++; end
      check(wake_hold, 1'b1);
      check(core_rst_n, 1'b1);
      while (wake_hold !== 1'b0 && n < 40) begin @(posedge clk_sys); n++; end
      check(wake_hold, 1'b0);
      $display("test wake done");
   endtask : t_wake

   // Fuses: brownout off, lower trip, delay with a real-time part
   task automatic t_fuses;
      @(posedge clk_sys);
      fuses <= 6'h11; // Brownout disabled, upper trip
      i_rss_source_model.set_brown(1'b1);
      repeat (BHI + 20) @(posedge clk_sys);
      #1;
      check(core_rst_n, 1'b1);
      @(posedge clk_sys);
      i_rss_source_model.set_brown(1'b0);
      repeat (6) @(posedge clk_sys);
      fuses <= 6'h0E; // Short real-time part, lower trip
      repeat (2) @(posedge clk_sys);
      #1;
      check(bod_level_sel, 1'b0);
      @(posedge clk_sys);
      i_rss_source_model.fire_wdt();
      repeat (12) @(posedge clk_sys);
      #1;
      check(core_rst_n, 1'b0);
      wait_release(40);
      check(core_rst_n, 1'b1);
      rd(ADDR, 32'h8);
      wr(ADDR, 32'h0);
      @(posedge clk_sys);
      fuses <= 6'h13;
      $display("test fuses done");
   endtask : t_fuses

   // Supply drop after a watchdog reset clears the other flags
   task automatic t_supply;
      @(posedge clk_sys);
      i_rss_source_model.fire_wdt();
      repeat (2) @(posedge clk_sys);
      wait_release(40);
      rd(ADDR, 32'h8);
      @(posedge clk_sys);
      i_rss_source_model.set_supply(1'b0);
      #1;
      check(core_rst_n, 1'b0);
      repeat (3) @(posedge clk_sys);
      i_rss_source_model.set_supply(1'b1);
      wait_release(60);
      check(core_rst_n, 1'b1);
      rd(ADDR, 32'h1);
      $display("test supply done");
   endtask : t_supply

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (6) @(posedge clk_sys);
      t_power_on();
      t_pin();
      t_wdt();
      t_brown();
      t_layout();
      t_wake();
      t_fuses();
      t_supply();
      wrap_up();
   end
endmodule : tb
